// ==== srs_monitor.sv ====
// port checker for the suspend/resume sequencer
`timescale 1ns/10ps
`default_nettype none
module srs_monitor
  import srs_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = 2
)
(
  // clock and reset
  input wire logic              clk_sys_i,
  input wire logic              reset_n_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // power and clock controls
  input wire logic              hdd_pwr_o,
  input wire logic              cdfd_pwr_o,
  input wire logic [LP_N-1:0]   lp_req_o,
  input wire logic [CLK_N-1:0]  dev_clk_en_o,
  input wire logic              clkgen_en_o,
  input wire logic              modem_clk_en_o,
  input wire logic              sys_off_o,
  input wire logic              smi_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  // smi_o trails the flag by a cycle, so a clear shows only two edges on
  logic smi_clr_d_r;

  always_ff @(posedge clk_sys_i)
    smi_clr_d_r <= reg_wr_i && (reg_addr_i == OFS_CMD) && reg_wdata_i[CMD_SMI_CLR];

  a_modem_running: assert property (modem_clk_en_o)
    else $error("modem clock stopped");
  a_gen_off_dark: assert property (!clkgen_en_o |-> dev_clk_en_o == '0 && !cdfd_pwr_o)
    else $error("clock left running with generator off");
  a_drive_first: assert property ($fell(cdfd_pwr_o) |->
    lp_req_o == '0 ##STEP_CYCLES lp_req_o == 5'h1f)
    else $error("low power force out of step with drive power off");
  a_gate_then_gen: assert property ($fell(dev_clk_en_o[1]) && clkgen_en_o |->
    lp_req_o == 5'h1f ##STEP_CYCLES !clkgen_en_o)
    else $error("generator not gated one step after device clocks");
  a_resume_order: assert property ($rose(clkgen_en_o) |-> dev_clk_en_o == '0
    ##STEP_CYCLES dev_clk_en_o == 6'h3f ##STEP_CYCLES cdfd_pwr_o && lp_req_o == '0)
    else $error("resume steps out of order");
  a_off_dark: assert property (sys_off_o |-> !clkgen_en_o && !hdd_pwr_o && dev_clk_en_o == '0)
    else $error("machine off with power or clocks on");
  a_smi_held: assert property (smi_o && !smi_clr_d_r |=> smi_o)
    else $error("interrupt dropped without clear");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside read slot");

  c_mem_sleep: cover property (!clkgen_en_o && !sys_off_o);
  c_disk_off: cover property ($rose(sys_off_o));
  c_smi_raise: cover property ($rose(smi_o));
endmodule

bind srs_sequencer srs_monitor #(.STEP_CYCLES(STEP_CYCLES)) u_mon (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .hdd_pwr_o(hdd_pwr_o), .cdfd_pwr_o(cdfd_pwr_o),
  .lp_req_o(lp_req_o), .dev_clk_en_o(dev_clk_en_o), .clkgen_en_o(clkgen_en_o),
  .modem_clk_en_o(modem_clk_en_o), .sys_off_o(sys_off_o), .smi_o(smi_o));
`default_nettype wire

// ==== srs_partner.sv ====
// far-side model: lid switch, keyboards, pointer, alarm and battery monitor
`timescale 1ns/10ps
`default_nettype none
module srs_partner
  import srs_pkg::*;
(
  // bench requests, one bit per pin position
  input  wire logic [PIN_N-1:0] ev_i,
  // pins toward the sequencer
  output logic      [PIN_N-1:0] pin_o
);
  // switches move off the clock edge so the synchronisers do real work
  assign #3 pin_o[PIN_LID]   = ev_i[PIN_LID];
  assign #3 pin_o[PIN_ALARM] = ev_i[PIN_ALARM];
  assign #3 pin_o[PIN_KINT]  = ev_i[PIN_KINT];
  assign #3 pin_o[PIN_KEXT]  = ev_i[PIN_KEXT];
  assign #3 pin_o[PIN_MOUSE] = ev_i[PIN_MOUSE];
  assign #3 pin_o[PIN_BATT]  = ev_i[PIN_BATT];
endmodule
`default_nettype wire

// ==== srs_pkg.sv ====
// constants, register map and state encoding for the suspend/resume sequencer
package srs_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STEP_TIME_NS  = 1000;
  localparam int unsigned STEP_CYC      = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CMD   = 8'h04;
  localparam logic [7:0] OFS_SCHED = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0C;

  // control register fields
  localparam int unsigned CTRL_DISK_MODE  = 0;
  localparam int unsigned CTRL_DISK_BLOCK = 1;

  // command register fields, each a one-shot
  localparam int unsigned CMD_SUSPEND  = 0;
  localparam int unsigned CMD_BATT_LOW = 1;
  localparam int unsigned CMD_SAVED    = 2;
  localparam int unsigned CMD_DATE_OK  = 3;
  localparam int unsigned CMD_DATE_BAD = 4;
  localparam int unsigned CMD_SMI_CLR  = 5;

  // schedule register fields
  localparam int unsigned SCHED_EN   = 0;
  localparam int unsigned SCHED_PAST = 1;

  // status register fields
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_CAUSE_LSB = 4;
  localparam int unsigned STAT_SMI       = 8;
  localparam int unsigned STAT_OFF       = 9;
  localparam int unsigned STAT_DISK      = 10;

  // wake cause bit positions
  localparam int unsigned CAUSE_LID  = 0;
  localparam int unsigned CAUSE_TIME = 1;
  localparam int unsigned CAUSE_KEY  = 2;
  localparam int unsigned CAUSE_BATT = 3;

  // synchronised pin positions
  localparam int unsigned PIN_LID   = 0;
  localparam int unsigned PIN_ALARM = 1;
  localparam int unsigned PIN_KINT  = 2;
  localparam int unsigned PIN_KEXT  = 3;
  localparam int unsigned PIN_MOUSE = 4;
  localparam int unsigned PIN_BATT  = 5;
  localparam int unsigned PIN_N     = 6;

  // low-power request and clock gate vector widths
  localparam int unsigned LP_N  = 5;
  localparam int unsigned CLK_N = 6;

  typedef enum logic [3:0] {
    ST_RUN,
    ST_PWR_OFF,
    ST_LOW_PWR,
    ST_CLK_OFF,
    ST_MEM,
    ST_SAVE,
    ST_OFF,
    ST_GEN_ON,
    ST_CLK_ON,
    ST_PWR_ON,
    ST_CHECK
  } srs_state_e;

endpackage

// ==== srs_sequencer.sv ====
// suspend-to-memory / suspend-to-disk sequencer with wake source evaluation
//
// Overview of operation
// - memory suspend stops all clocks except refresh and modem
// - suspend powers off drives; disk mode spares HDD
// - suspend entry forces small devices low power
// - static devices reach low power by clock gating
// - memory suspend deasserts clock generator enable
// - modem clocks stay running throughout suspend
// - after state saved, disk suspend powers off
// - only lid opening wakes from disk suspend
// - past date: wake on time match alone
// - future date: wake, compare, else re-suspend
// - successful scheduled wake clears schedule enable
// - schedule enable blocks disk suspend unless battery
// - lid resumes memory suspend, reboots after disk
// - internal or primary external key wakes memory
// - pointing device motion never wakes the system
// - very low battery in suspend raises SMI; the code raises it in memory suspend only
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module srs_sequencer
  import srs_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = STEP_CYC
)
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              reset_n_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // wake sources, asynchronous pins
  input  wire logic              lid_open_i,
  input  wire logic              alarm_match_i,
  input  wire logic              key_int_act_i,
  input  wire logic              key_ext_act_i,
  input  wire logic              mouse_act_i,
  input  wire logic              batt_vlow_i,
  // drive power
  output logic                   hdd_pwr_o,
  output logic                   cdfd_pwr_o,
  // low-power requests: audio, transceiver, fast ir, kbd ctrl, card ctrl
  output logic      [LP_N-1:0]   lp_req_o,
  // device clock enables: video, cpu, ide, isa, serial, floppy
  output logic      [CLK_N-1:0]  dev_clk_en_o,
  // clock generator and modem clocks
  output logic                   clkgen_en_o,
  output logic                   modem_clk_en_o,
  // machine power and system management interrupt
  output logic                   sys_off_o,
  output logic                   smi_o
);

  if (STEP_CYCLES < 1 || STEP_CYCLES > 65535)
    $error("srs_sequencer: STEP_CYCLES out of range");

  logic [PIN_N-1:0] pin_meta_r;
  logic [PIN_N-1:0] pin_sync_r;
  logic             lid_prev_r;

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
      lid_prev_r <= 1'b0;
    end
    else
    begin
      pin_meta_r <= {batt_vlow_i, mouse_act_i, key_ext_act_i,
                     key_int_act_i, alarm_match_i, lid_open_i};
      pin_sync_r <= pin_meta_r;
      lid_prev_r <= pin_sync_r[PIN_LID];
    end
  end

  logic lid_rise;
  logic key_wake;
  logic time_hit;
  logic batt_hit;

  assign lid_rise = pin_sync_r[PIN_LID] & ~lid_prev_r;
  // pointer motion is synchronised but read by no register and feeds no wake term
  assign key_wake = pin_sync_r[PIN_KINT] | pin_sync_r[PIN_KEXT];
  assign batt_hit = pin_sync_r[PIN_BATT];

  logic       disk_mode_r;
  logic       disk_block_r;
  logic       sched_en_r;
  logic       sched_past_r;
  logic [3:0] cause_r;
  logic       smi_r;

  logic wr_ctrl;
  logic wr_cmd;
  logic wr_sched;
  logic wr_stat;
  assign wr_ctrl  = reg_wr_i && (reg_addr_i == OFS_CTRL);
  assign wr_cmd   = reg_wr_i && (reg_addr_i == OFS_CMD);
  assign wr_sched = reg_wr_i && (reg_addr_i == OFS_SCHED);
  assign wr_stat  = reg_wr_i && (reg_addr_i == OFS_STAT);

  logic cmd_suspend;
  logic cmd_batt;
  logic cmd_saved;
  logic cmd_date_ok;
  logic cmd_date_bad;
  assign cmd_suspend  = wr_cmd & reg_wdata_i[CMD_SUSPEND];
  assign cmd_batt     = wr_cmd & reg_wdata_i[CMD_BATT_LOW];
  assign cmd_saved    = wr_cmd & reg_wdata_i[CMD_SAVED];
  assign cmd_date_ok  = wr_cmd & reg_wdata_i[CMD_DATE_OK];
  assign cmd_date_bad = wr_cmd & reg_wdata_i[CMD_DATE_BAD];

  assign time_hit = pin_sync_r[PIN_ALARM] & sched_en_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      disk_mode_r  <= 1'b0;
      disk_block_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      disk_mode_r  <= reg_wdata_i[CTRL_DISK_MODE];
      disk_block_r <= reg_wdata_i[CTRL_DISK_BLOCK];
    end
  end

  srs_state_e  state_r;
  srs_state_e  state_nxt;
  logic [15:0] step_cnt_r;
  logic        step_done;
  logic        disk_sel_r;
  logic        mem_wake;
  logic        sched_done;

  assign step_done = (step_cnt_r == 16'h0000);
  assign mem_wake  = lid_rise | key_wake | batt_hit | time_hit;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN:
        if (cmd_suspend)
          state_nxt = ST_PWR_OFF;
      ST_PWR_OFF:
        if (step_done)
          state_nxt = ST_LOW_PWR;
      ST_LOW_PWR:
        if (step_done)
          state_nxt = disk_sel_r ? ST_SAVE : ST_CLK_OFF;
      ST_CLK_OFF:
        if (step_done)
          state_nxt = ST_MEM;
      ST_MEM:
        if (mem_wake)
          state_nxt = ST_GEN_ON;
      ST_SAVE:
        if (cmd_saved)
          state_nxt = ST_OFF;
      ST_OFF:
        if (lid_rise)
          state_nxt = ST_GEN_ON;
      ST_GEN_ON:
        if (step_done)
          state_nxt = ST_CLK_ON;
      ST_CLK_ON:
        if (step_done)
          state_nxt = ST_PWR_ON;
      ST_PWR_ON:
        if (step_done)
          state_nxt = (cause_r[CAUSE_TIME] && !sched_past_r && !disk_sel_r)
                      ? ST_CHECK : ST_RUN;
      ST_CHECK:
        if (cmd_date_ok)
          state_nxt = ST_RUN;
        else if (cmd_date_bad)
          state_nxt = ST_PWR_OFF;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      state_r    <= ST_RUN;
      step_cnt_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        step_cnt_r <= 16'(STEP_CYCLES - 1);
      else if (!step_done)
        step_cnt_r <= step_cnt_r - 16'h0001;
    end
  end

  // schedule enable blocks disk mode unless the battery forced the suspend
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      disk_sel_r <= 1'b0;
    else if (state_r == ST_RUN && cmd_suspend)
      disk_sel_r <= disk_mode_r & ~disk_block_r & (~sched_en_r | cmd_batt);
    else if (state_r == ST_CHECK)
      disk_sel_r <= 1'b0;
  end

  // a past date wakes on the time match alone; a future date waits for the verdict
  assign sched_done = (state_r == ST_PWR_ON && step_done && cause_r[CAUSE_TIME]
                       && sched_past_r)
                      || (state_r == ST_CHECK && cmd_date_ok);

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      sched_en_r   <= 1'b0;
      sched_past_r <= 1'b0;
    end
    else if (sched_done)
      sched_en_r <= 1'b0;
    else if (wr_sched)
    begin
      sched_en_r   <= reg_wdata_i[SCHED_EN];
      sched_past_r <= reg_wdata_i[SCHED_PAST];
    end
  end

  // wake causes are sticky, write one to clear; a new cause wins over the clear
  logic [3:0] cause_set;
  always_comb
  begin
    cause_set = 4'h0;
    if (state_r == ST_MEM)
    begin
      cause_set[CAUSE_LID]  = lid_rise;
      cause_set[CAUSE_TIME] = time_hit;
      cause_set[CAUSE_KEY]  = key_wake;
      cause_set[CAUSE_BATT] = batt_hit;
    end
    else if (state_r == ST_OFF)
      cause_set[CAUSE_LID] = lid_rise;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      cause_r <= 4'h0;
    else if ((state_r == ST_RUN && cmd_suspend) || (state_r == ST_CHECK && cmd_date_bad))
      cause_r <= 4'h0;
    else
      cause_r <= (cause_r & ~(wr_stat ? reg_wdata_i[STAT_CAUSE_LSB +: 4] : 4'h0))
                 | cause_set;
  end

  // smi stays up until software clears it; a new battery event wins
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      smi_r <= 1'b0;
    else if (state_r == ST_MEM && batt_hit)
      smi_r <= 1'b1;
    else if (wr_cmd && reg_wdata_i[CMD_SMI_CLR])
      smi_r <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      hdd_pwr_o      <= 1'b1;
      cdfd_pwr_o     <= 1'b1;
      lp_req_o       <= '0;
      dev_clk_en_o   <= '1;
      clkgen_en_o    <= 1'b1;
      modem_clk_en_o <= 1'b1;
      sys_off_o      <= 1'b0;
      smi_o          <= 1'b0;
    end
    else
    begin
      modem_clk_en_o <= 1'b1;
      smi_o          <= smi_r;
      sys_off_o      <= (state_r == ST_OFF);
      unique case (state_r)
        ST_PWR_OFF, ST_LOW_PWR, ST_CLK_OFF, ST_MEM, ST_GEN_ON, ST_CLK_ON:
          hdd_pwr_o <= disk_sel_r;
        ST_OFF:
          hdd_pwr_o <= 1'b0;
        default:
          hdd_pwr_o <= 1'b1;
      endcase
      unique case (state_r)
        ST_RUN, ST_PWR_ON, ST_CHECK:
          cdfd_pwr_o <= 1'b1;
        default:
          cdfd_pwr_o <= 1'b0;
      endcase
      unique case (state_r)
        ST_RUN, ST_PWR_OFF, ST_PWR_ON, ST_CHECK:
          lp_req_o <= '0;
        default:
          lp_req_o <= '1;
      endcase
      unique case (state_r)
        ST_CLK_OFF, ST_MEM, ST_OFF, ST_GEN_ON:
          dev_clk_en_o <= '0;
        default:
          dev_clk_en_o <= '1;
      endcase
      // only the refresh and modem clocks survive while the generator is off
      unique case (state_r)
        ST_MEM, ST_OFF:
          clkgen_en_o <= 1'b0;
        default:
          clkgen_en_o <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= '0;
    else if (reg_rd_i)
    begin
      reg_rdata_o <= '0;
      unique case (reg_addr_i)
        OFS_CTRL:
        begin
          reg_rdata_o[CTRL_DISK_MODE]  <= disk_mode_r;
          reg_rdata_o[CTRL_DISK_BLOCK] <= disk_block_r;
        end
        OFS_SCHED:
        begin
          reg_rdata_o[SCHED_EN]   <= sched_en_r;
          reg_rdata_o[SCHED_PAST] <= sched_past_r;
        end
        OFS_STAT:
        begin
          reg_rdata_o[STAT_STATE_LSB +: 4] <= state_r;
          reg_rdata_o[STAT_CAUSE_LSB +: 4] <= cause_r;
          reg_rdata_o[STAT_SMI]            <= smi_r;
          reg_rdata_o[STAT_OFF]            <= (state_r == ST_OFF);
          reg_rdata_o[STAT_DISK]           <= disk_sel_r;
        end
        default:
          reg_rdata_o <= '0;
      endcase
    end
    else
      reg_rdata_o <= '0;
  end

endmodule

`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the suspend/resume sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench
  import srs_pkg::*;
;
  localparam int unsigned N = 2;
  logic              clk_sys_i = 1'b0;
  logic              reset_n_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [PIN_N-1:0]  ev = '0;
  logic [PIN_N-1:0]  pin;
  logic              hdd_pwr_o, cdfd_pwr_o, clkgen_en_o, modem_clk_en_o, sys_off_o, smi_o;
  logic [LP_N-1:0]   lp_req_o;
  logic [CLK_N-1:0]  dev_clk_en_o;
  logic              snap = 1'b0;
  logic              rd_seen = 1'b0;
  int                n_errors = 0;
  int                compares = 0;
  int                seed = 82;
  int                i;
  logic [31:0]       r;
  logic [31:0]       exp_q[$];
  string             nm_q[$];
  wire [31:0] outs = {15'h0, smi_o, sys_off_o, modem_clk_en_o, clkgen_en_o,
                      dev_clk_en_o, lp_req_o, cdfd_pwr_o, hdd_pwr_o};
  wire [3:0]  flg = {lp_req_o[0], sys_off_o, cdfd_pwr_o, clkgen_en_o};

  always #5 clk_sys_i = ~clk_sys_i;

  srs_partner u_far (.ev_i(ev), .pin_o(pin));
  srs_sequencer #(.STEP_CYCLES(N)) dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .lid_open_i(pin[PIN_LID]), .alarm_match_i(pin[PIN_ALARM]),
    .key_int_act_i(pin[PIN_KINT]), .key_ext_act_i(pin[PIN_KEXT]),
    .mouse_act_i(pin[PIN_MOUSE]), .batt_vlow_i(pin[PIN_BATT]), .hdd_pwr_o(hdd_pwr_o),
    .cdfd_pwr_o(cdfd_pwr_o), .lp_req_o(lp_req_o), .dev_clk_en_o(dev_clk_en_o),
    .clkgen_en_o(clkgen_en_o), .modem_clk_en_o(modem_clk_en_o), .sys_off_o(sys_off_o),
    .smi_o(smi_o));

  function automatic logic [31:0] pk(logic s, logic o, logic g, logic [5:0] d,
                                     logic [4:0] l, logic [1:0] p);
    return {15'h0, s, o, 1'b1, g, d, l, p};
  endfunction

  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // results come out of the queue in the order the driver noted them
  always @(posedge clk_sys_i)
  begin
    rd_seen <= reg_rd_i;
    if ((rd_seen || snap) && exp_q.size() > 0)
      check(nm_q.pop_front(), rd_seen ? reg_rdata_o : outs, exp_q.pop_front());
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    // idle edge so a following write never sets the strobe twice in one step
    @(posedge clk_sys_i);
  endtask

  // one idle slot after the read keeps its check apart from a snapshot
  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic look(logic [31:0] e, string nm);
    @(posedge clk_sys_i);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    snap <= 1'b1;
    @(posedge clk_sys_i);
    snap <= 1'b0;
  endtask

  // sel: 0 generator, 1 drive power, 2 machine off, 3 low power force
  task automatic wt(int sel, logic v);
    for (int k = 0; k < 300; k++)
    begin
      if (flg[sel] === v)
        return;
      @(posedge clk_sys_i);
    end
    n_errors++;
    $display("timeout waiting on output %0d", sel);
    summarize();
  endtask

  task automatic wake(int p);
    ev[p] <= 1'b1;
    wt(1, 1'b1);
    ev[p] <= 1'b0;
    repeat (N) @(posedge clk_sys_i);
  endtask

  task automatic disk_cycle(logic [31:0] cmd);
    logic [31:0] off_v;
    off_v = pk(0, 1, 0, 6'h00, 5'h1f, 2'b00);
    wr(OFS_CMD, cmd);
    wt(3, 1'b1);
    look(pk(0, 0, 1, 6'h3f, 5'h1f, 2'b01), "disk entry");
    wr(OFS_CMD, 32'h0000_0004);
    wt(2, 1'b1);
    look(off_v, "off");
    rd(OFS_STAT, 32'h0000_0606, "off status");
    ev[PIN_KINT] <= 1'b1;
    ev[PIN_ALARM] <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    look(off_v, "off held");
    ev[PIN_KINT] <= 1'b0;
    ev[PIN_ALARM] <= 1'b0;
    wake(PIN_LID);
    look(pk(0, 0, 1, 6'h3f, 5'h00, 2'b11), "lid power on");
    $display("test disk %h done", cmd);
  endtask

  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    look(pk(0, 0, 1, 6'h3f, 5'h00, 2'b11), "reset outputs");
    for (i = 0; i < 4; i++)
    begin
      r = $random(seed);
      wr(OFS_CTRL, r);
      rd(OFS_CTRL, r & 32'h0000_0003, "ctrl");
    end
    wr(OFS_CTRL, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000, "hole");
    rd(OFS_CMD, 32'h0000_0000, "cmd");
    $display("test registers done");
    for (i = 0; i < 3; i++)
    begin
      wr(OFS_CTRL, i == 2 ? 32'h0000_0003 : 32'h0000_0000);
      wr(OFS_CMD, 32'h0000_0001);
      wt(0, 1'b0);
      look(pk(0, 0, 0, 6'h00, 5'h1f, 2'b00), "mem outputs");
      rd(OFS_STAT, 32'h0000_0004, "mem state");
      repeat (20)
      begin
        ev[PIN_MOUSE] <= 1'($random(seed));
        @(posedge clk_sys_i);
      end
      ev[PIN_MOUSE] <= 1'b0;
      look(pk(0, 0, 0, 6'h00, 5'h1f, 2'b00), "mouse ignored");
      wake(i == 2 ? PIN_LID : PIN_KINT + i);
      look(pk(0, 0, 1, 6'h3f, 5'h00, 2'b11), "mem resume");
      rd(OFS_STAT, i == 2 ? 32'h0000_0010 : 32'h0000_0040, "cause");
      $display("test memory wake %0d done", i);
    end
    wr(OFS_CTRL, 32'h0000_0001);
    disk_cycle(32'h0000_0001);
    wr(OFS_SCHED, 32'h0000_0001);
    wr(OFS_CMD, 32'h0000_0001);
    wt(0, 1'b0);
    look(pk(0, 0, 0, 6'h00, 5'h1f, 2'b00), "sched blocks disk");
    for (i = 0; i < 2; i++)
    begin
      wake(PIN_ALARM);
      rd(OFS_STAT, 32'h0000_002a, "date check");
      wr(OFS_CMD, i ? 32'h0000_0008 : 32'h0000_0010);
      if (i == 0)
        wt(0, 1'b0);
      rd(OFS_SCHED, i ? 32'h0000_0000 : 32'h0000_0001, "sched en");
    end
    wr(OFS_SCHED, 32'h0000_0003);
    wr(OFS_CMD, 32'h0000_0001);
    wt(0, 1'b0);
    wake(PIN_ALARM);
    rd(OFS_STAT, 32'h0000_0020, "past date");
    rd(OFS_SCHED, 32'h0000_0002, "auto clear");
    disk_cycle(32'h0000_0001);
    wr(OFS_SCHED, 32'h0000_0001);
    disk_cycle(32'h0000_0003);
    wr(OFS_SCHED, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0001);
    wt(0, 1'b0);
    wake(PIN_BATT);
    look(pk(1, 0, 1, 6'h3f, 5'h00, 2'b11), "smi raised");
    rd(OFS_STAT, 32'h0000_0180, "batt cause");
    wr(OFS_CMD, 32'h0000_0020);
    rd(OFS_STAT, 32'h0000_0080, "smi cleared");
    wr(OFS_STAT, 32'h0000_0080);
    rd(OFS_STAT, 32'h0000_0000, "cause cleared");
    $display("test schedule and battery done");
    summarize();
  end
endmodule
`default_nettype wire
